// file: hw/fcmd_pkg.sv
// constants for the floppy command interpreter
package fcmd_pkg;
  localparam logic [4:0] OP_DUMP     = 5'h0E;
  localparam logic [4:0] OP_READID   = 5'h0A;
  localparam logic [4:0] OP_PERP     = 5'h12;
  localparam logic [4:0] OP_LOCK     = 5'h14;
  localparam logic [4:0] OP_CONFIG   = 5'h13;
  localparam logic [4:0] OP_SPECIFY  = 5'h03;
  localparam logic [4:0] OP_READ     = 5'h06;
  localparam logic [4:0] OP_WRITE    = 5'h05;
  localparam logic [4:0] OP_VERIFY   = 5'h16;
  localparam logic [4:0] OP_FORMAT   = 5'h0D;
  localparam logic [7:0] STATUS_REG_ZERO_INVALID = 8'h80;
  localparam logic [7:0] STATUS_REG_ZERO_SEEKERR = 8'h70;
  localparam int         LOCK_BIT    = 7;
  localparam int         LOCK_ECHO   = 4;
  localparam int         DOUBLE_DENSITY_BIT = 6;
  localparam int         XFER_PARAMS = 8;
  localparam int         RES_XFER    = 7;
  localparam int         RES_DUMP    = 10;
  localparam logic [7:0] CFG_RESET   = 8'h20;
  localparam logic [7:0] SPEC1_RESET = 8'h00;
  localparam logic [7:0] SPEC2_RESET = 8'h00;
  typedef enum logic [2:0] {FC_IDLE, FC_PARAM, FC_SEEK, FC_EXEC, FC_RESULT} fcmd_state_t;
endpackage

// file: hw/fcmd_result_mux.sv
// result byte selector
`timescale 1ns/1ps
`default_nettype none
module fcmd_result_mux (
  input  wire logic [3:0]  idx,
  input  wire logic [79:0] bytes_in,
  output logic      [7:0]  byte_out
);
  assign byte_out = (idx < 4'hA) ? bytes_in[idx*8 +: 8] : 8'h00;
endmodule
`default_nettype wire

// file: hw/fcmd_core.sv
// command-phase interpreter for a floppy controller subset
`timescale 1ns/1ps
`default_nettype none
module fcmd_core
  import fcmd_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       CMD_WR,
  input  wire logic [7:0] CMD_DATA,
  input  wire logic       RES_RD,
  output logic      [7:0] RES_DATA,
  output logic      [7:0] MAIN_STATUS,
  output logic            STANDBY,
  output logic            SEEK_REQ,
  output logic      [1:0] SEEK_DRIVE,
  output logic      [7:0] SEEK_CYL,
  input  wire logic       SEEK_DONE,
  input  wire logic       SEEK_FAIL,
  input  wire logic [7:0] SEEK_AT_CYL,
  output logic            XFER_START,
  output logic      [4:0] XFER_OP,
  input  wire logic       XFER_DONE,
  input  wire logic [55:0] XFER_RESULT,
  output logic            ID_REQ,
  output logic            ID_DOUBLE_DENSITY,
  input  wire logic       ID_FOUND,
  input  wire logic [55:0] ID_RESULT
);
  import fcmd_pkg::*;
  ////////////////////////////////////////////////////////////////////
  fcmd_state_t st_r, st_nxt;
  logic [4:0]  op_r;
  logic [7:0]  cmd0_r;
  logic [3:0]  pcnt_r;
  logic [3:0]  rcnt_r;
  logic [3:0]  rlen_r;
  logic [79:0] res_r;
  logic [7:0]  pcyl_r [4];
  logic [7:0]  spec1_r, spec2_r, cfg_r, precomp_start_track_r, perp_r, sectors_per_cylinder_r, end_of_track_sector_r;
  logic        lock_r, last_fmt_r, standby_r;
  logic [1:0]  drv_r;
  logic [7:0]  cyl_r;
  logic [3:0]  need;
  logic [7:0]  rbyte;

  function automatic logic is_xfer(input logic [4:0] op);
    is_xfer = (op == OP_READ) || (op == OP_WRITE) || (op == OP_VERIFY);
  endfunction

  // parameter bytes following the opcode
  function automatic logic [3:0] nparams(input logic [4:0] op);
    case (op)
      OP_READID, OP_PERP: nparams = 4'h1;
      OP_SPECIFY:         nparams = 4'h2;
      OP_CONFIG:          nparams = 4'h3;
      OP_FORMAT:          nparams = 4'h5;
      default:            nparams = is_xfer(op) ? 4'(XFER_PARAMS) : 4'h0;
    endcase
  endfunction

  wire       known    = is_xfer(CMD_DATA[4:0]) || (CMD_DATA[4:0] == OP_DUMP) || (CMD_DATA[4:0] == OP_READID)
                        || (CMD_DATA[4:0] == OP_PERP) || (CMD_DATA[4:0] == OP_LOCK)
                        || (CMD_DATA[4:0] == OP_CONFIG) || (CMD_DATA[4:0] == OP_SPECIFY)
                        || (CMD_DATA[4:0] == OP_FORMAT);
  wire       take_op  = (st_r == FC_IDLE) && CMD_WR;
  wire       take_par = (st_r == FC_PARAM) && CMD_WR;
  wire       last_par = take_par && (pcnt_r == need - 4'h1);
  // implied seek enable from configure
  wire       implied_seek_enable = cfg_r[6];
  wire [7:0] count_or_end        = last_fmt_r ? sectors_per_cylinder_r : end_of_track_sector_r;
  assign need = nparams(op_r);

  wire [79:0] dump_bytes = {precomp_start_track_r, cfg_r, lock_r, perp_r[6:0], count_or_end, spec2_r, spec1_r,
                            pcyl_r[3], pcyl_r[2], pcyl_r[1], pcyl_r[0]};

  fcmd_result_mux u_mux (
    .idx      (rcnt_r),
    .bytes_in (res_r),
    .byte_out (rbyte)
  );
  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      FC_IDLE: begin
        if (CMD_WR) begin
          if (!known || CMD_DATA[4:0] == OP_DUMP || CMD_DATA[4:0] == OP_LOCK)
            st_nxt = FC_RESULT;
          else
            st_nxt = FC_PARAM;
        end
      end
      FC_PARAM: begin
        if (last_par)
          st_nxt = (is_xfer(op_r) && implied_seek_enable) ? FC_SEEK
                   : ((is_xfer(op_r) || op_r == OP_READID) ? FC_EXEC : FC_IDLE);
      end
      FC_SEEK: begin
        if (SEEK_FAIL)
          st_nxt = FC_RESULT;
        else if (SEEK_DONE)
          st_nxt = FC_EXEC;
      end
      FC_EXEC: begin
        if ((op_r == OP_READID && ID_FOUND) || (op_r != OP_READID && XFER_DONE))
          st_nxt = FC_RESULT;
      end
      FC_RESULT: begin
        if (RES_RD && rcnt_r == rlen_r - 4'h1)
          st_nxt = FC_IDLE;
      end
      default: st_nxt = FC_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_r <= FC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      op_r <= 5'h00; cmd0_r <= 8'h00; pcnt_r <= 4'h0; rcnt_r <= 4'h0; rlen_r <= 4'h0; res_r <= '0;
      spec1_r <= SPEC1_RESET; spec2_r <= SPEC2_RESET; cfg_r <= CFG_RESET; precomp_start_track_r <= 8'h00;
      perp_r <= 8'h00; sectors_per_cylinder_r <= 8'h00; end_of_track_sector_r <= 8'h00; lock_r <= 1'b0;
      last_fmt_r <= 1'b0;
      standby_r <= 1'b0; drv_r <= 2'h0; cyl_r <= 8'h00;
      for (int i = 0; i < 4; i++) pcyl_r[i] <= 8'h00;
    end else begin
      if (take_op) begin
        op_r <= CMD_DATA[4:0]; cmd0_r <= CMD_DATA; pcnt_r <= 4'h0; rcnt_r <= 4'h0;
        standby_r <= 1'b0;
        if (!known) begin
          standby_r <= 1'b1; rlen_r <= 4'h1; res_r <= {72'h0, STATUS_REG_ZERO_INVALID};
        end else if (CMD_DATA[4:0] == OP_DUMP) begin
          rlen_r <= 4'(RES_DUMP); res_r <= dump_bytes;
        end else if (CMD_DATA[4:0] == OP_LOCK) begin
          lock_r <= CMD_DATA[LOCK_BIT]; rlen_r <= 4'h1;
          res_r <= {72'h0, 3'b000, CMD_DATA[LOCK_BIT], 4'h0};
        end
      end
      if (take_par) begin
        pcnt_r <= pcnt_r + 4'h1;
        if (pcnt_r == 4'h0) drv_r <= CMD_DATA[1:0];
        if (pcnt_r == 4'h1 && is_xfer(op_r)) cyl_r <= CMD_DATA;
        if (pcnt_r == 4'h5 && is_xfer(op_r)) end_of_track_sector_r <= CMD_DATA;
        if (pcnt_r == 4'h2 && op_r == OP_FORMAT) sectors_per_cylinder_r <= CMD_DATA;
        if (op_r == OP_SPECIFY && pcnt_r == 4'h0) spec1_r <= CMD_DATA;
        if (op_r == OP_SPECIFY && pcnt_r == 4'h1) spec2_r <= CMD_DATA;
        if (op_r == OP_CONFIG && pcnt_r == 4'h1) cfg_r <= CMD_DATA;
        if (op_r == OP_CONFIG && pcnt_r == 4'h2) precomp_start_track_r <= CMD_DATA;
        if (op_r == OP_PERP) perp_r <= CMD_DATA;
        if (last_par && (is_xfer(op_r) || op_r == OP_FORMAT)) last_fmt_r <= (op_r == OP_FORMAT);
      end
      if (st_r == FC_SEEK && SEEK_DONE && !SEEK_FAIL) pcyl_r[drv_r] <= cyl_r;
      // failed seek result
      // transfer results are not valid during a seek, so the tail bytes stay zero
      if (st_r == FC_SEEK && SEEK_FAIL) begin
        pcyl_r[drv_r] <= SEEK_AT_CYL; rlen_r <= 4'(RES_XFER); rcnt_r <= 4'h0;
        res_r <= {48'h0, SEEK_AT_CYL, 8'h00, 8'h00, STATUS_REG_ZERO_SEEKERR | {6'h00, drv_r}};
      end
      if (st_r == FC_EXEC && op_r == OP_READID && ID_FOUND) begin
        rlen_r <= 4'(RES_XFER); rcnt_r <= 4'h0; res_r <= {24'h0, ID_RESULT};
      end
      if (st_r == FC_EXEC && op_r != OP_READID && XFER_DONE) begin
        rlen_r <= 4'(RES_XFER); rcnt_r <= 4'h0; res_r <= {24'h0, XFER_RESULT};
      end
      if (st_r == FC_RESULT && RES_RD) rcnt_r <= rcnt_r + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) RES_DATA <= 8'h00;
    else RES_DATA <= rbyte;
  end

  wire [3:0] busy = (st_r == FC_SEEK) ? (4'h1 << drv_r) : 4'h0;
  assign MAIN_STATUS = {(st_r == FC_IDLE) || (st_r == FC_PARAM) || (st_r == FC_RESULT),
                        st_r == FC_RESULT, st_r == FC_EXEC, st_r != FC_IDLE, busy};
  assign STANDBY           = standby_r;
  assign SEEK_REQ          = (st_r == FC_SEEK);
  assign SEEK_DRIVE        = drv_r;
  assign SEEK_CYL          = cyl_r;
  assign XFER_START        = (st_r == FC_EXEC) && (op_r != OP_READID);
  assign XFER_OP           = op_r;
  assign ID_REQ            = (st_r == FC_EXEC) && (op_r == OP_READID);
  assign ID_DOUBLE_DENSITY = cmd0_r[DOUBLE_DENSITY_BIT];

  ////////////////////////////////////////////////////////////////////
  AST_INVALID_RES: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    take_op && !known |=> st_r == FC_RESULT && rlen_r == 4'h1 && res_r[7:0] == 8'h80 && STANDBY)
    else $error("invalid code result wrong");
  AST_LOCK_ECHO: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    take_op && CMD_DATA[4:0] == OP_LOCK |=> res_r[7:0] == {3'b000, $past(CMD_DATA[7]), 4'h0} && lock_r == $past(CMD_DATA[7]))
    else $error("lock echo wrong");
  AST_DUMP_LEN: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    take_op && CMD_DATA[4:0] == OP_DUMP |=> rlen_r == 4'hA && res_r[79:72] == precomp_start_track_r)
    else $error("dump length wrong");
  AST_DUMP_SC: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    take_op && CMD_DATA[4:0] == OP_DUMP |=> res_r[55:48] == (last_fmt_r ? sectors_per_cylinder_r : end_of_track_sector_r))
    else $error("dump count byte wrong");
  AST_BUSY_SEEK: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    SEEK_REQ |-> MAIN_STATUS[drv_r])
    else $error("busy bit missing in seek");
  AST_SEEK_FAIL: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    SEEK_REQ && SEEK_FAIL |=> res_r[31:24] == $past(SEEK_AT_CYL) && rlen_r == 4'h7)
    else $error("seek fail cylinder wrong");
  AST_IMPLIED_SEEK: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    last_par && is_xfer(op_r) && implied_seek_enable |=> SEEK_REQ)
    else $error("implied seek not started");
  AST_READID_DENSITY: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    take_op |=> ID_DOUBLE_DENSITY == $past(CMD_DATA[DOUBLE_DENSITY_BIT]))
    else $error("density select not taken from command");
  AST_READID_LEN: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ID_REQ && ID_FOUND |=> rlen_r == 4'h7 && res_r[55:0] == $past(ID_RESULT))
    else $error("read id result wrong");
endmodule
`default_nettype wire

// file: bench/fcmd_drive_model.sv
// drive-side responder for seek, transfer and id requests
`timescale 1ns/1ps
`default_nettype none
module fcmd_drive_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        fail_mode,
  input  wire logic        seek_req,
  input  wire logic        xfer_req,
  input  wire logic        id_req,
  output logic             seek_done,
  output logic             seek_fail,
  output logic      [7:0]  seek_at,
  output logic             xfer_done,
  output logic      [55:0] xfer_res,
  output logic             id_found,
  output logic      [55:0] id_res
);
  logic [3:0] seek_cnt_r, xc_r, ic_r;
  // late answers so the busy phases can be observed
  always_ff @(posedge clk) begin
    seek_cnt_r <= (rst || !seek_req) ? 4'h0 : seek_cnt_r + {3'h0, seek_cnt_r != 4'hF};
    xc_r <= (rst || !xfer_req) ? 4'h0 : xc_r + {3'h0, xc_r != 4'hF};
    ic_r <= (rst || !id_req) ? 4'h0 : ic_r + {3'h0, ic_r != 4'hF};
  end
  assign seek_done = seek_req && seek_cnt_r == 4'h3 && !fail_mode;
  assign seek_fail = seek_req && seek_cnt_r == 4'h3 && fail_mode;
  assign xfer_done = xfer_req && xc_r == 4'h3;
  assign id_found  = id_req && ic_r == 4'h3;
  // data outside its pulse is inverted, never a stale copy
  assign seek_at   = seek_fail ? 8'h2C : 8'hD3;
  assign xfer_res  = xfer_done ? 56'h1D1C1B1A191817 : ~56'h1D1C1B1A191817;
  assign id_res    = id_found ? 56'h2D2C2B2A292827 : ~56'h2D2C2B2A292827;
endmodule
`default_nettype wire

// file: bench/floppy_cmd_misc_and_xfer_setup_test.sv
// self-checking bench for the floppy command interpreter
`timescale 1ns/1ps
`default_nettype none
module floppy_cmd_misc_and_xfer_setup_test;
  import fcmd_pkg::*;
  logic        SYS_CLK = 1'b0, SYS_RST = 1'b1, CMD_WR = 1'b0, RES_RD = 1'b0, fail_mode = 1'b0;
  logic [7:0]  CMD_DATA = 8'h00, RES_DATA, MAIN_STATUS, SEEK_CYL, SEEK_AT_CYL;
  logic        STANDBY, SEEK_REQ, SEEK_DONE, SEEK_FAIL, XFER_START, XFER_DONE, ID_REQ, ID_FOUND;
  logic        ID_DOUBLE_DENSITY;
  logic [1:0]  SEEK_DRIVE;
  logic [4:0]  XFER_OP;
  logic [55:0] XFER_RESULT, ID_RESULT;
  int          mismatches = 0, n_checks = 0;
  fcmd_core uut (.SYS_CLK, .SYS_RST, .CMD_WR, .CMD_DATA, .RES_RD, .RES_DATA, .MAIN_STATUS, .STANDBY,
    .SEEK_REQ, .SEEK_DRIVE, .SEEK_CYL, .SEEK_DONE, .SEEK_FAIL, .SEEK_AT_CYL, .XFER_START, .XFER_OP,
    .XFER_DONE, .XFER_RESULT, .ID_REQ, .ID_DOUBLE_DENSITY, .ID_FOUND, .ID_RESULT);
  fcmd_drive_model drv (.clk(SYS_CLK), .rst(SYS_RST), .fail_mode(fail_mode), .seek_req(SEEK_REQ),
    .xfer_req(XFER_START), .id_req(ID_REQ), .seek_done(SEEK_DONE), .seek_fail(SEEK_FAIL),
    .seek_at(SEEK_AT_CYL), .xfer_done(XFER_DONE), .xfer_res(XFER_RESULT), .id_found(ID_FOUND),
    .id_res(ID_RESULT));
  always #50 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic tick();
    @(posedge SYS_CLK);
    #1;
  endtask
  // one idle cycle after each command keeps the strobe edges apart
  task automatic cmd(input logic [7:0] q[$]);
    foreach (q[k]) begin
      CMD_DATA = q[k];
      CMD_WR = 1'b1;
      tick();
    end
    CMD_WR = 1'b0;
    tick();
  endtask
  task automatic wt(input int s);
    int i;
    i = 0;
    while ((s == 0 ? SEEK_REQ : s == 1 ? XFER_START : s == 2 ? ID_REQ : MAIN_STATUS[6]) !== 1'b1 && i < 200) begin
      tick();
      i++;
    end
    if (i == 200) begin
      $display("MISMATCH wait %0d expected 1 seen 0", s);
      mismatches++;
      tally_and_finish();
    end
  endtask
  // all bytes are drained; only those marked in m are compared
  task automatic res(input logic [7:0] q[$], input logic [15:0] m);
    foreach (q[k]) begin
      wt(3);
      tick();
      if (m[k]) chk("result byte", q[k], RES_DATA);
      RES_RD = 1'b1;
      tick();
      RES_RD = 1'b0;
    end
    chk("ready after results", 8'h80, MAIN_STATUS & 8'hC0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_lock();
    cmd('{8'h94});
    res('{8'h10}, 16'h1);
    cmd('{8'h14});
    res('{8'h00}, 16'h1);
  endtask
  task automatic t_invalid();
    cmd('{8'h01});
    wt(3);
    chk("standby", 8'h01, {7'h0, STANDBY});
    res('{STATUS_REG_ZERO_INVALID}, 16'h1);
    cmd('{8'h14});
    chk("standby cleared", 8'h00, {7'h0, STANDBY});
    res('{8'h00}, 16'h1);
  endtask
  task automatic t_dump();
    cmd('{8'h03, 8'hA5, 8'h5B});
    cmd('{8'h13, 8'h00, 8'h47, 8'h0B});
    cmd('{8'h94});
    res('{8'h10}, 16'h1);
    cmd('{8'h12, 8'h3C});
    cmd('{8'h0E});
    res('{8'h00, 8'h00, 8'h00, 8'h00, 8'hA5, 8'h5B, 8'h00, 8'hBC, 8'h47, 8'h0B}, 16'h3FF);
  endtask
  task automatic t_count(input logic [7:0] v);
    cmd('{8'h0E});
    res('{8'h05, 8'h22, 8'h00, 8'h4F, 8'hA5, 8'h5B, v, 8'hBC, 8'h47, 8'h0B}, 16'h3FF);
  endtask
  task automatic t_xfer(input logic [4:0] op, input logic [1:0] d, input logic [7:0] cyl);
    // drive bits match the host selection
    cmd('{{3'h0, op}, {6'h0, d}, cyl, 8'h00, 8'h01, 8'h02, 8'h12, 8'h1B, 8'hFF});
    wt(0);
    chk("seek drive", {6'h0, d}, {6'h0, SEEK_DRIVE});
    chk("seek cylinder", cyl, SEEK_CYL);
    chk("drive busy", 8'h10 | (8'h01 << d), MAIN_STATUS & 8'h1F);
    if (!fail_mode) begin
      wt(1);
      chk("opcode", {3'h0, op}, {3'h0, XFER_OP});
      res('{8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D}, 16'h7F);
    end else
      res('{{6'h1C, d}, 8'h00, 8'h00, 8'h2C, 8'h00, 8'h00, 8'h00}, 16'h7F);
  endtask
  task automatic t_readid(input logic dd);
    cmd('{{1'b0, dd, 6'h0A}, 8'h01});
    wt(2);
    chk("density", {7'h0, dd}, {7'h0, ID_DOUBLE_DENSITY});
    res('{8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D}, 16'h7F);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) tick();
    SYS_RST = 1'b0;
    t_lock();
    t_invalid();
    t_dump();
    t_xfer(OP_READ, 2'h1, 8'h22);
    t_xfer(OP_WRITE, 2'h0, 8'h05);
    t_xfer(OP_VERIFY, 2'h3, 8'h4F);
    t_count(8'h12);
    cmd('{8'h0D, 8'h00, 8'h02, 8'h09, 8'h54, 8'hE5});
    chk("format leaves no results", 8'h80, MAIN_STATUS & 8'hC0);
    t_count(8'h09);
    fail_mode = 1'b1;
    t_xfer(OP_VERIFY, 2'h2, 8'h30);
    fail_mode = 1'b0;
    t_readid(1'b0);
    t_readid(1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
